// ### key_unlock_pkg.sv
/*
 * constants shared by the backdoor key unlock block: key addresses, word
 * width, security field encodings and sequence states.
 * assumes a 16-bit cpu bus addressing flash by byte address.
 */
package key_unlock_pkg;

    localparam int          KEY_WORDS        = 4;
    localparam int          KEY_WIDTH        = 16;
    localparam int          ADDR_WIDTH       = 16;
    localparam int          KEY_IDX_WIDTH    = 3;
    localparam logic [15:0] KEY_BASE_ADDR    = 16'hFF00;
    localparam logic [15:0] KEY_LAST_ADDR    = 16'hFF06;
    localparam logic [15:0] KEY_ALL_ZERO     = 16'h0000;
    localparam logic [15:0] KEY_ALL_ONE      = 16'hFFFF;
    localparam logic [1:0]  SEC_UNSECURE     = 2'h2;
    localparam logic [1:0]  KEYEN_ENABLED    = 2'h2;
    localparam logic [2:0]  KEY_COUNT_ZERO   = 3'h0;
    localparam logic [2:0]  KEY_COUNT_ONE    = 3'h1;
    localparam logic [2:0]  KEY_COUNT_FULL   = 3'h4;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_ACCESS,
        ST_LOCKED,
        ST_UNSECURED
    } seq_state_t;

endpackage

// ### key_write_if.sv
/*
 * interface carrying one checked key write from the checker to the
 * sequence tracker.
 * assumes both ends share the block clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface key_write_if;
    import key_unlock_pkg::*;

    logic                     hit;
    logic [KEY_IDX_WIDTH-1:0] index;
    logic                     in_range;
    logic                     word_match;
    logic                     word_legal;

    modport checker_end
    (
        output hit,
        output index,
        output in_range,
        output word_match,
        output word_legal
    );
    modport seq_end
    (
        input hit,
        input index,
        input in_range,
        input word_match,
        input word_legal
    );
endinterface

`default_nettype wire

// ### key_word_check.sv
/*
 * combinational check of one cpu write against the stored key words.
 * assumes the stored keys are stable while key access is enabled.
 */
`timescale 1ns/1ps
`default_nettype none

module key_word_check
    import key_unlock_pkg::*;
(
    input  wire logic                              wr_en,
    input  wire logic [ADDR_WIDTH-1:0]             wr_addr,
    input  wire logic [KEY_WIDTH-1:0]              wr_data,
    input  wire logic [KEY_WORDS*KEY_WIDTH-1:0]    stored_keys,
    key_write_if.checker_end                       chk
);

    // ***************************************************************
    // key window decode
    // ***************************************************************
    logic [ADDR_WIDTH-1:0] offset;
    logic [KEY_WIDTH-1:0]  stored_word;

    assign offset       = wr_addr - KEY_BASE_ADDR;
    assign chk.in_range = (wr_addr >= KEY_BASE_ADDR) && (wr_addr <= KEY_LAST_ADDR)
                          && !wr_addr[0];
    assign chk.index    = offset[KEY_IDX_WIDTH:1];
    assign chk.hit      = wr_en && chk.in_range;
    assign stored_word  = stored_keys[chk.index[1:0]*KEY_WIDTH +: KEY_WIDTH];

    assign chk.word_match = (wr_data == stored_word);                      // [RULE1]
    assign chk.word_legal = (wr_data != KEY_ALL_ZERO) && (wr_data != KEY_ALL_ONE); // [RULE12]

endmodule

`default_nettype wire

// ### key_seq_tracker.sv
/*
 * running record of one key sequence: word count, expected index,
 * accumulated verdict and back-to-back write detection.
 * assumes it is cleared by the sequencer at the start of each sequence.
 */
`timescale 1ns/1ps
`default_nettype none

module key_seq_tracker
    import key_unlock_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     clear,
    key_write_if.seq_end                  kw,
    output var  logic [KEY_IDX_WIDTH-1:0] count,
    output var  logic                     all_good,
    output var  logic                     violation
);

    typedef struct packed
    {
        logic [KEY_IDX_WIDTH-1:0] count;
        logic                     all_good;
        logic                     prev_hit;
    } trk_t;

    trk_t trk_reg;
    trk_t trk_next;

    // ***************************************************************
    // per-write checks
    // ***************************************************************
    always_comb
    begin
        trk_next  = trk_reg;
        violation = 1'b0;
        if (clear)
        begin
            trk_next.count    = KEY_COUNT_ZERO;
            trk_next.all_good = 1'b1;
            trk_next.prev_hit = 1'b0;
        end
        else
        begin
            trk_next.prev_hit = kw.hit;
            if (kw.hit)
            begin
                if (trk_reg.count >= KEY_COUNT_FULL)
                    violation = 1'b1;                                      // [RULE11]
                if (kw.index != trk_reg.count)
                    violation = 1'b1;                                      // [RULE10]
                if (!kw.word_legal)
                    violation = 1'b1;                                      // [RULE12]
                if (trk_reg.prev_hit)
                    violation = 1'b1;                                      // [RULE14]
                // a mismatch is only acted on when access closes
                trk_next.all_good = trk_reg.all_good & kw.word_match;      // [RULE20]
                trk_next.count    = trk_reg.count + KEY_COUNT_ONE;         // [RULE20]
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            trk_reg <= '{count: KEY_COUNT_ZERO, all_good: 1'b1, prev_hit: 1'b0};
        else if (ce)
            trk_reg <= trk_next;
    end

    assign count    = trk_reg.count;
    assign all_good = trk_reg.all_good;

endmodule

`default_nettype wire

// ### flash_backdoor_key_unlock.sv
/*
 * security state machine for backdoor key unsecuring of the flash.
 * assumes cpu writes arrive as one-cycle strobes on clk, and that the
 * stored keys, security byte and key enable field come from flash.
 */
// Overview of operation
// (RULE1) with key access on, a key-address write is compared with the stored key
// (RULE2) software writes the four key words in ascending address order
// (RULE3) four matching words unsecure the part and force the unsecure state
// (RULE4) while key access is on, flash reads return invalid data
// (RULE5) backdoor unsecuring is possible only with the key enable field enabled
// (RULE6) software sets key access, writes four words, then clears key access
// (RULE7) any illegal operation during the sequence locks the state machine
// (RULE8) reset releases the lock so a new attempt can be made
// (RULE9) any mismatching word locks
// (RULE10) words out of address order lock
// (RULE11) a fifth or later key write locks
// (RULE12) a key word of all zeros or all ones locks
// (RULE13) clearing key access before four words are written locks
// (RULE14) key writes on consecutive cycles lock
// (RULE15) unlock never changes the stored security byte; reset re-derives state
// (RULE16) the stored key words are left unchanged
// (RULE17) program and erase protection settings are untouched
// (RULE18) debug-port key writes in special single-chip mode never unsecure
// (RULE19) once unsecured, software may reprogram the stored keys
// (RULE20) keep a word count and verdict, judge only when access clears
`timescale 1ns/1ps
`default_nettype none

module flash_backdoor_key_unlock
    import key_unlock_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire logic                           key_access_enable,
    input  wire logic                           wr_en,
    input  wire logic [ADDR_WIDTH-1:0]          wr_addr,
    input  wire logic [KEY_WIDTH-1:0]           wr_data,
    input  wire logic                           wr_from_debug,
    input  wire logic                           special_single_chip,
    input  wire logic [KEY_WORDS*KEY_WIDTH-1:0] stored_keys,
    input  wire logic [1:0]                     stored_security_field,
    input  wire logic [1:0]                     backdoor_enable_field,
    output logic      [1:0]                     security_state_field,
    output logic                                unsecured,
    output logic                                locked,
    output logic                                read_invalid,
    output logic                                key_program_allow
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed
    {
        seq_state_t st;
        logic       kacc_d;
        logic       loaded;
        logic [1:0] sec;
        logic       rd_inv;
        logic       unsec;
        logic       lock;
    } state_t;

    state_t s_reg;
    state_t s_next;

    key_write_if kw ();

    logic [KEY_IDX_WIDTH-1:0] count;
    logic                     all_good;
    logic                     violation;
    logic                     trk_clear;
    logic                     valid_wr;

    // debug-port writes in special single-chip mode are dropped from the
    // compare path entirely, so they can never complete a sequence
    assign valid_wr = wr_en && key_access_enable
                      && !(wr_from_debug && special_single_chip);          // [RULE18]

    key_word_check u_check
    (
        .wr_en       (valid_wr),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .stored_keys (stored_keys),
        .chk         (kw.checker_end)
    );

    key_seq_tracker u_track
    (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .clear     (trk_clear),
        .kw        (kw.seq_end),
        .count     (count),
        .all_good  (all_good),
        .violation (violation)
    );

    // ***************************************************************
    // sequencer
    // ***************************************************************
    always_comb
    begin
        s_next        = s_reg;
        trk_clear     = 1'b0;
        s_next.kacc_d = key_access_enable;
        if (!s_reg.loaded)
        begin
            // security comes from the stored byte after every reset
            s_next.sec    = stored_security_field;                         // [RULE15]
            s_next.loaded = 1'b1;
        end
        unique case (s_reg.st)
            ST_IDLE:
            begin
                trk_clear = 1'b1;
                if (key_access_enable && !s_reg.kacc_d)
                    s_next.st = ST_ACCESS;                                 // [RULE1]
            end
            ST_ACCESS:
            begin
                if (violation)
                    s_next.st = ST_LOCKED;                                 // [RULE7]
                else if (!key_access_enable)
                begin
                    if (count != KEY_COUNT_FULL)
                        s_next.st = ST_LOCKED;                             // [RULE13]
                    else if (!all_good)
                        s_next.st = ST_LOCKED;                             // [RULE9]
                    else if (backdoor_enable_field != KEYEN_ENABLED)
                        s_next.st = ST_IDLE;                               // [RULE5]
                    else
                    begin
                        s_next.st  = ST_UNSECURED;                         // [RULE20]
                        s_next.sec = SEC_UNSECURE;                         // [RULE3]
                    end
                end
            end
            ST_LOCKED:
                s_next.st = ST_LOCKED;                                     // [RULE8]
            ST_UNSECURED:
                s_next.sec = SEC_UNSECURE;                                 // [RULE3]
        endcase
        s_next.rd_inv = key_access_enable;                                 // [RULE4]
        s_next.lock   = (s_next.st == ST_LOCKED);
        s_next.unsec  = (s_next.st == ST_UNSECURED);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '{st: ST_IDLE, kacc_d: 1'b0, loaded: 1'b0, sec: 2'h0,
                       rd_inv: 1'b0, unsec: 1'b0, lock: 1'b0};             // [RULE8]
        else if (ce)
            s_reg <= s_next;
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    // the block only reports state; it has no write path to stored keys,
    // security byte or protection register, so none can be altered
    assign security_state_field = s_reg.sec;                               // [RULE15] [RULE16] [RULE17]
    assign unsecured            = s_reg.unsec;
    assign locked               = s_reg.lock;
    assign read_invalid         = s_reg.rd_inv;                            // [RULE4]
    assign key_program_allow    = s_reg.unsec;                             // [RULE19]

    // ***************************************************************
    // checks
    // ***************************************************************
    a_lock_sticks: assert property (@(posedge clk) disable iff (rst)
        ce && locked |=> locked)                                           // [RULE8]
        else $error("lock state left without reset");

    a_b2b_locks: assert property (@(posedge clk) disable iff (rst)
        ce && s_reg.st == ST_ACCESS && kw.hit && $past(kw.hit) && $past(ce)
        && $past(s_reg.st) == ST_ACCESS |=> locked)                        // [RULE14]
        else $error("back to back key writes did not lock");

    a_bad_word_locks: assert property (@(posedge clk) disable iff (rst)
        ce && s_reg.st == ST_ACCESS && kw.hit && !kw.word_legal
        |=> locked)                                                        // [RULE12]
        else $error("all zero or all one key did not lock");

    a_order_locks: assert property (@(posedge clk) disable iff (rst)
        ce && s_reg.st == ST_ACCESS && kw.hit && kw.index != count
        |=> locked)                                                        // [RULE10]
        else $error("out of order key did not lock");

    a_early_clear: assert property (@(posedge clk) disable iff (rst)
        ce && s_reg.st == ST_ACCESS && !key_access_enable
        && count != KEY_COUNT_FULL |=> locked)                             // [RULE13]
        else $error("early key access clear did not lock");

    a_unsec_field: assert property (@(posedge clk) disable iff (rst)
        unsecured |-> security_state_field == SEC_UNSECURE)                // [RULE3]
        else $error("unsecured without unsecure field");

    a_keyen_gate: assert property (@(posedge clk) disable iff (rst)
        ce && !unsecured && backdoor_enable_field != KEYEN_ENABLED
        |=> !unsecured)                                                    // [RULE5]
        else $error("unsecured with backdoor disabled");

    a_read_inv: assert property (@(posedge clk) disable iff (rst)
        ce && key_access_enable |=> read_invalid)                          // [RULE4]
        else $error("reads not invalid during key access");

    a_debug_ignored: assert property (@(posedge clk) disable iff (rst)
        wr_en && wr_from_debug && special_single_chip |-> !kw.hit)         // [RULE18]
        else $error("debug write reached key compare");

endmodule

`default_nettype wire

// ### key_cpu_model.sv
/*
 * behavioural cpu software issuing key access and key writes.
 * assumes the bench calls its tasks; signals change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module key_cpu_model
    import key_unlock_pkg::*;
(
    input  wire logic                  clk,
    output var  logic                  key_access_enable,
    output var  logic                  wr_en,
    output var  logic [ADDR_WIDTH-1:0] wr_addr,
    output var  logic [KEY_WIDTH-1:0]  wr_data,
    output var  logic                  wr_from_debug
);
    initial
    begin
        key_access_enable = 1'b0;
        wr_en             = 1'b0;
        wr_addr           = 16'h0000;
        wr_data           = 16'h0000;
        wr_from_debug     = 1'b0;
    end

    // a released bus shows the inverse of its last value, so a second idle cycle shows the old value again
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge clk);
            wr_en   = 1'b0;
            wr_addr = ~wr_addr;
            wr_data = ~wr_data;
        end
    endtask

    task automatic set_access(input logic v);
        @(negedge clk);
        wr_en             = 1'b0;
        key_access_enable = v;
    endtask

    // one-cycle strobe; the caller decides the idle gap that follows
    task automatic write_key(input logic [15:0] a, input logic [15:0] d, input logic dbg);
        @(negedge clk);
        wr_en         = 1'b1;
        wr_addr       = a;
        wr_data       = d;
        wr_from_debug = dbg;
    endtask
endmodule

`default_nettype wire

// ### flash_backdoor_key_unlock_bench.sv
/*
 * self-checking bench for the backdoor key unlock block.
 * assumes the cpu model drives the write port at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_backdoor_key_unlock_bench;
    import key_unlock_pkg::*;

    logic        clk;
    logic        rst;
    logic        ce;
    logic        key_access_enable;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic        wr_from_debug;
    logic        ssc;
    logic [63:0] keys;
    logic [1:0]  sec_stored;
    logic [1:0]  keyen;
    logic [1:0]  security_state_field;
    logic        unsecured;
    logic        locked;
    logic        read_invalid;
    logic        key_program_allow;
    int          errors;
    int          checks;
    int          seed;
    logic [15:0] addr_q[$];
    logic [15:0] data_q[$];
    int          gap_q[$];
    logic        dbg;

    key_cpu_model cpu_u (.clk(clk), .key_access_enable(key_access_enable), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_from_debug(wr_from_debug));

    flash_backdoor_key_unlock dut_u (.clk(clk), .rst(rst), .ce(ce),
        .key_access_enable(key_access_enable), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_from_debug(wr_from_debug), .special_single_chip(ssc),
        .stored_keys(keys), .stored_security_field(sec_stored),
        .backdoor_enable_field(keyen), .security_state_field(security_state_field),
        .unsecured(unsecured), .locked(locked), .read_invalid(read_invalid),
        .key_program_allow(key_program_allow));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************************************
    // checking and reference model
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // mismatch is judged only at the end, other faults lock at once
    task automatic model(output logic lk, output logic un);
        int cnt;
        bit bad;
        bit good;
        cnt  = 0;
        bad  = 0;
        good = 1;
        for (int i = 0; i < addr_q.size(); i++)
        begin
            if (dbg && ssc)
                continue;
            if (i > 0 && gap_q[i-1] == 0)
                bad = 1;
            if (cnt >= 4 || addr_q[i] != 16'hFF00 + 16'(2 * cnt))
                bad = 1;
            if (data_q[i] == KEY_ALL_ZERO || data_q[i] == KEY_ALL_ONE)
                bad = 1;
            if (data_q[i] != keys[16 * ((addr_q[i] - 16'hFF00) / 2) +: 16])
                good = 0;
            cnt++;
        end
        lk = bad || cnt != 4 || !good;
        un = !lk && keyen == KEYEN_ENABLED;
    endtask

    task automatic reset_dut();
        @(negedge clk);
        rst = 1'b1;
        ce  = 1'($random(seed));
        for (int i = 0; i < 4; i++)
            keys[16*i +: 16] = $random(seed) | 16'h0010;
        keys[15:0] = keys[15:0] & 16'hF7FF;
        sec_stored = 2'($random(seed));
        repeat (2) @(negedge clk);
        ce  = 1'b1;
        rst = 1'b0;
        cpu_u.idle(3);
        check(16'(locked), 16'h0000);
        check(16'(unsecured), 16'h0000);
        check(16'(security_state_field), 16'(sec_stored));
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic lk;
        logic un;
        errors = 0;
        checks = 0;
        seed   = 32'h4a53;
        rst    = 1'b1;
        ce     = 1'b1;
        ssc    = 1'b0;
        keys   = 64'h1111_2222_3333_4444;
        sec_stored = 2'h0;
        keyen  = KEYEN_ENABLED;
        dbg    = 1'b0;
        for (int k = 0; k < 10; k++)
        begin
            reset_dut();
            keyen = (k == 7) ? 2'h1 : KEYEN_ENABLED;
            ssc   = (k == 8);
            dbg   = (k >= 8);
            addr_q.delete();
            data_q.delete();
            gap_q.delete();
            for (int i = 0; i < 4; i++)
            begin
                addr_q.push_back(16'hFF00 + 16'(2 * i));
                data_q.push_back(keys[16*i +: 16]);
                gap_q.push_back(1 + ($random(seed) & 1));
            end
            case (k)
                1: data_q[2] = data_q[2] ^ 16'h0100;
                2:
                begin
                    addr_q[1] = 16'hFF04;
                    addr_q[2] = 16'hFF02;
                    data_q[1] = keys[47:32];
                    data_q[2] = keys[31:16];
                end
                3:
                begin
                    addr_q.push_back(16'hFF00);
                    data_q.push_back(keys[15:0]);
                    gap_q.push_back(1);
                end
                4: data_q[1] = ($random(seed) & 1) ? KEY_ALL_ONE : KEY_ALL_ZERO;
                5: void'(addr_q.pop_back());
                6: gap_q[2] = 0;
                default: ;
            endcase
            cpu_u.set_access(1'b1);
            cpu_u.idle(2);
            check(16'(read_invalid), 16'h0001);
            for (int i = 0; i < addr_q.size(); i++)
            begin
                cpu_u.write_key(addr_q[i], data_q[i], dbg);
                cpu_u.idle(gap_q[i]);
            end
            cpu_u.set_access(1'b0);
            cpu_u.idle(2);
            model(lk, un);
            check(16'(locked), 16'(lk));
            check(16'(unsecured), 16'(un));
            check(16'(key_program_allow), 16'(un));
            check(16'(security_state_field), un ? 16'(SEC_UNSECURE) : 16'(sec_stored));
            check(16'(read_invalid), 16'h0000);
            // with the clock enable low no state may move
            @(negedge clk);
            ce = 1'b0;
            cpu_u.set_access(1'b1);
            cpu_u.idle(2);
            check(16'(read_invalid), 16'h0000);
            check(16'(locked), 16'(lk));
            cpu_u.set_access(1'b0);
            ce = 1'b1;
            $display("test %0d done", k);
        end
        reset_dut();
        stop_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule

`default_nettype wire
